/* bbc_bin2bcd.sv */
// combinational binary magnitude to seven-digit bcd (shift and add three)
`timescale 1ns/1ps
module bbc_bin2bcd
  import bbc_pkg::*;
(
  input wire logic [MAG_W-1:0] bin_in,
  output logic [BCD_W-1:0] bcd_out
);
  logic [BCD_W-1:0] stage [0:MAG_W];
  assign stage[0] = '0;

  genvar b, d;
  generate
    for (b = 0; b < MAG_W; b++) begin : g_bit
      logic [BCD_W-1:0] adj;
      for (d = 0; d < DIGITS; d++) begin : g_dig
        logic [DIGIT_W-1:0] cur;
        assign cur = stage[b][d*DIGIT_W +: DIGIT_W];
        assign adj[d*DIGIT_W +: DIGIT_W] = (cur >= DABBLE_LIM) ? DIGIT_W'(cur + DABBLE_ADD) : cur;
      end
      assign stage[b+1] = {adj[BCD_W-2:0], bin_in[MAG_W-1-b]};
    end
  endgenerate

  assign bcd_out = stage[MAG_W];
endmodule

/* bbc_converter.sv */
// signed bcd/binary number converter with registered result
// Function
// - decimal mode turns bcd into binary; binary mode turns binary into bcd.
// - while enabled, the conversion is redone every scan cycle.
// - immediate style registers a new result on the clock edge after the operand changes.
// - hold style keeps each result stable until the following scan cycle.
// - operand and result are each one 32-bit double word.
// - each decimal digit of a bcd value sits in its own nibble.
// - top nibble is the sign, leaving seven magnitude digits.
// - sign nibble is all zeros for positive, all ones for negative.
// - enable low clears the result to zero.
// - release option clear means always enabled, enable input ignored.
// - result spans plus or minus 9 999 999 as a decimal integer.
`timescale 1ns/1ps
module bbc_converter
  import bbc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic scan_tick_in,
  input wire bbc_cfg_t cfg_in,
  input wire logic [WORD_W-1:0] operand_in,
  output logic [WORD_W-1:0] converted_out,
  output logic range_error_out,
  output logic updated_out
);
  bbc_result_t result_r;
  bbc_result_t result_nxt;
  logic updated_r;
  logic updated_nxt;

  // operand fields
  logic [DIGIT_W-1:0] sign_nib;
  logic [BCD_W-1:0] bcd_digits;
  logic bcd_neg;
  logic bcd_bad_digit;
  logic bcd_bad_sign;

  assign sign_nib = operand_in[SIGN_LSB +: DIGIT_W];
  assign bcd_digits = operand_in[BCD_W-1:0];

  // all ones negative, all zeros positive
  always_comb begin
    bcd_neg = 1'b0;
    bcd_bad_sign = 1'b0;
    case (sign_nib)
      SIGN_POS: begin
        bcd_neg = 1'b0;
        bcd_bad_sign = 1'b0;
      end
      SIGN_NEG: begin
        bcd_neg = 1'b1;
        bcd_bad_sign = 1'b0;
      end
      default: begin
        // unknown sign read as positive, flagged
        bcd_neg = 1'b0;
        bcd_bad_sign = 1'b1;
      end
    endcase
  end

  // bcd to binary, most significant digit first
  logic [BCD_W-1:0] acc [0:DIGITS];
  logic [DIGITS-1:0] digit_bad;
  assign acc[0] = '0;

  genvar k;
  generate
    for (k = 0; k < DIGITS; k++) begin : g_bcd
      logic [DIGIT_W-1:0] dig;
      assign dig = bcd_digits[(DIGITS-1-k)*DIGIT_W +: DIGIT_W];
      assign digit_bad[k] = (dig > DIGIT_MAX);
      assign acc[k+1] = BCD_W'(acc[k] * DEC_BASE) + BCD_W'(dig);
    end
  endgenerate

  // any digit nibble above nine is flagged
  always_comb begin
    bcd_bad_digit = 1'b0;
    if (digit_bad != '0) begin
      bcd_bad_digit = 1'b1;
    end
  end

  logic [WORD_W-1:0] bcd_mag;
  logic [WORD_W-1:0] bcd_to_bin;
  assign bcd_mag = {{(WORD_W-BCD_W){1'b0}}, acc[DIGITS]};

  // negative bcd gives two's complement
  always_comb begin
    bcd_to_bin = bcd_mag;
    if (bcd_neg) begin
      bcd_to_bin = WORD_W'(-bcd_mag);
    end
  end

  // binary to bcd: magnitude, clamp, then digits
  logic bin_neg;
  logic [WORD_W-1:0] bin_abs;
  logic bin_over;
  logic [MAG_W-1:0] bin_mag;
  logic [BCD_W-1:0] bin_digits;
  logic [WORD_W-1:0] bin_to_bcd;

  assign bin_neg = operand_in[WORD_W-1];

  // magnitude of the two's complement operand
  always_comb begin
    bin_abs = operand_in;
    if (bin_neg) begin
      bin_abs = WORD_W'(-operand_in);
    end
  end

  // out of range operand saturates at seven nines
  always_comb begin
    bin_over = (bin_abs > MAG_MAX);
    bin_mag = bin_abs[MAG_W-1:0];
    if (bin_over) begin
      bin_mag = MAG_MAX[MAG_W-1:0];
    end
  end

  bbc_bin2bcd u_bin2bcd (
    .bin_in(bin_mag),
    .bcd_out(bin_digits)
  );

  // sign nibble in front of the digits
  always_comb begin
    bin_to_bcd = {SIGN_POS, bin_digits};
    if (bin_neg) begin
      bin_to_bcd = {SIGN_NEG, bin_digits};
    end
  end

  // enable and take qualifiers
  logic active;
  logic take;
  bbc_result_t conv;
  always_comb begin
    active = 1'b1;
    if (cfg_in.enable_release) begin
      active = enable_in;
    end
    take = 1'b1;
    // hold style takes only at scan tick
    if (cfg_in.hold_style) begin
      take = scan_tick_in;
    end
  end

  always_comb begin
    conv.value = bcd_to_bin;
    conv.range_error = bcd_bad_digit || bcd_bad_sign;
    case (cfg_in.binary_to_decimal_mode)
      1'b1: begin
        conv.value = bin_to_bcd;
        conv.range_error = bin_over;
      end
      default: begin
        conv.value = bcd_to_bin;
        conv.range_error = bcd_bad_digit || bcd_bad_sign;
      end
    endcase
  end

  // result next value
  always_comb begin
    result_nxt = result_r;
    if (!active) begin
      result_nxt.value = RESULT_CLEAR;
      result_nxt.range_error = 1'b0;
    end else if (take) begin
      result_nxt = conv;
    end else begin
      // hold style between scan ticks
      result_nxt = result_r;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

  // one-cycle pulse per take
  always_comb begin
    updated_nxt = 1'b0;
    if (active && take) begin
      updated_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      updated_r <= 1'b0;
    end else begin
      updated_r <= updated_nxt;
    end
  end

  // ports come straight from the registers
  assign converted_out = result_r.value;
  assign range_error_out = result_r.range_error;
  assign updated_out = updated_r;
endmodule

/* bbc_converter_sva.sv */
// assertions on the converter ports
`timescale 1ns/1ps
module bbc_converter_sva
  import bbc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic scan_tick_in,
  input wire bbc_cfg_t cfg_in,
  input wire logic [WORD_W-1:0] operand_in,
  input wire logic [WORD_W-1:0] converted_out,
  input wire logic updated_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  wire act = !cfg_in.enable_release || enable_in;
  wire tk = act && (!cfg_in.hold_style || scan_tick_in);
  wire b2d = tk && cfg_in.binary_to_decimal_mode;
  wire d2b = tk && !cfg_in.binary_to_decimal_mode;
  AST_UPD: assert property (tk |=> updated_out) else $error("no update");
  AST_NOUPD: assert property (!tk |=> !updated_out) else $error("stray update");
  AST_HOLD: assert property (act && !tk |=> $stable(converted_out)) else $error("not held");
  AST_CLR: assert property (!act |=> converted_out == 0) else $error("not cleared");
  AST_IGN: assert property (!cfg_in.enable_release && !enable_in && !cfg_in.hold_style |=> updated_out)
    else $error("enable not ignored");
  AST_POS: assert property (b2d && !operand_in[31] |=> converted_out[31:28] == SIGN_POS)
    else $error("bad plus sign");
  AST_NEG: assert property (b2d && operand_in[31] |=> converted_out[31:28] == SIGN_NEG)
    else $error("bad minus sign");
  AST_D2B: assert property (d2b && operand_in[31:28] == SIGN_NEG && |operand_in[27:0] |=> converted_out[31])
    else $error("bcd sign lost");
endmodule
bind bbc_converter bbc_converter_sva chk(.clk_sys_in, .reset_n_in, .enable_in, .scan_tick_in, .cfg_in,
  .operand_in, .converted_out, .updated_out);

/* bbc_converter_tb.sv */
// bench for the bcd/binary converter
`timescale 1ns/1ps
module bbc_converter_tb;
  import bbc_pkg::*;
  logic clk_sys_in = 0, reset_n_in = 0, enable_in = 0, scan_tick_in = 0, range_error_out, updated_out;
  bbc_cfg_t cfg_in = '0;
  logic [31:0] operand_in = '0, converted_out, marker, rng = 32'h881F8F1E;
  int failures = 0, check_count = 0, cyc = 0;
  bbc_converter dut(.clk_sys_in, .reset_n_in, .enable_in, .scan_tick_in, .cfg_in, .operand_in,
    .converted_out, .range_error_out, .updated_out);
  bbc_marker mk(.clk_sys_in, .load_in(updated_out), .value_in(converted_out), .value_out(marker));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (++cyc > 5000) begin
    failures++;
    end_sim();
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [31:0] to_bcd(logic [31:0] v);
    int m = $signed(v) < 0 ? -$signed(v) : v;
    logic [31:0] r = $signed(v) < 0 ? 32'hF0000000 : 32'h0;
    for (int i = 0; i < 7; i++) begin
      r[i*4+:4] = m % 10;
      m /= 10;
    end
    return r;
  endfunction
  task chk(logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_flag(logic got, exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task step(logic en, tk, rel, md, hs, logic [31:0] op, ex, logic er);
    @(posedge clk_sys_in);
    enable_in <= en;
    scan_tick_in <= tk;
    cfg_in <= {rel, md, hs};
    operand_in <= op;
    @(posedge clk_sys_in);
    #1 chk(converted_out, ex);
    chk_flag(updated_out, (!rel | en) & (!hs | tk));
    chk_flag(range_error_out, er);
  endtask
  task end_sim();
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    logic [31:0] r, v;
    repeat (5) @(posedge clk_sys_in);
    reset_n_in <= 1;
    step(1, 0, 1, 0, 0, 32'hF0000123, 32'hFFFFFF85, 0);
    step(1, 0, 1, 1, 0, -32'h7B, 32'hF0000123, 0);
    step(1, 0, 1, 1, 0, -MAG_MAX, 32'hF9999999, 0);
    step(0, 0, 0, 1, 0, MAG_MAX, 32'h09999999, 0);
    step(1, 1, 1, 1, 1, 32'h42, 32'h66, 0);
    step(1, 0, 1, 1, 1, 32'h7, 32'h66, 0);
    step(0, 1, 1, 0, 0, 32'h42, 32'h0, 0);
    chk(marker, 32'h66);
    step(1, 0, 1, 1, 0, 32'h00989680, 32'h09999999, 1);
    step(1, 0, 1, 0, 0, 32'h5000000A, 32'h0000000A, 1);
    @(posedge clk_sys_in);
    reset_n_in <= 0;
    @(posedge clk_sys_in);
    #1 chk(converted_out, 32'h0);
    chk_flag(updated_out, 1'b0);
    chk_flag(range_error_out, 1'b0);
    @(posedge clk_sys_in);
    reset_n_in <= 1;
    for (int i = 0; i < 300; i++) begin
      r = xs();
      v = $signed(xs()) % 32'sd10000000;
      step(r[1], 0, r[2], r[0], 0, r[0] ? v : to_bcd(v), (r[1] | !r[2]) ? (r[0] ? to_bcd(v) : v) : 0, 0);
    end
    end_sim();
  end
endmodule

/* bbc_marker.sv */
// marker that keeps the last converted value
`timescale 1ns/1ps
module bbc_marker (
  input wire logic clk_sys_in,
  input wire logic load_in,
  input wire logic [31:0] value_in,
  output logic [31:0] value_out
);
  always_ff @(posedge clk_sys_in) if (load_in) value_out <= value_in;
endmodule

/* bbc_pkg.sv */
// shared constants and types for the bcd/binary converter
package bbc_pkg;
  localparam int WORD_W = 32;
  localparam int DIGIT_W = 4;
  localparam int DIGITS = 7;
  localparam int MAG_W = 24;
  localparam int BCD_W = DIGITS * DIGIT_W;
  localparam int SIGN_LSB = BCD_W;
  localparam logic [DIGIT_W-1:0] SIGN_POS = 4'h0;
  localparam logic [DIGIT_W-1:0] SIGN_NEG = 4'hF;
  localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
  localparam logic [DIGIT_W-1:0] DABBLE_LIM = 4'h5;
  localparam logic [DIGIT_W-1:0] DABBLE_ADD = 4'h3;
  localparam logic [BCD_W-1:0] DEC_BASE = 28'h000000A;
  localparam logic [WORD_W-1:0] MAG_MAX = 32'h0098967F;
  localparam logic [WORD_W-1:0] RESULT_CLEAR = 32'h00000000;

  typedef struct packed {
    logic enable_release;
    logic binary_to_decimal_mode;
    logic hold_style;
  } bbc_cfg_t;

  typedef struct packed {
    logic [WORD_W-1:0] value;
    logic range_error;
  } bbc_result_t;
endpackage
